//--- pkg/host_port_defines.vh
// constants for the host bus port of the motion controller
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH
`define STYLE_STROBE 2'h0
`define STYLE_WAIT 2'h1
`define STYLE_READY 2'h2
`define STYLE_BYTE 2'h3
`define ADDR_W 10
`define DATA_W 16
`define NUM_AXES 4
`define CLK_HZ 50000000
`define ACC_NS 60
`define ACC_CYC ((`ACC_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define BYTE_PAD 8'hff
`define REG_WORDS 512
`define ACC_IDLE 2'h0
`define ACC_WORK 2'h1
`define ACC_DONE 2'h2
`endif

//--- hdl/host_reg_mem.v
// small register memory behind the host port, registered read data
`timescale 1ns/1ns
`include "host_port_defines.vh"
module host_reg_mem (
  input wire sysClk,
  input wire wrEn,
  input wire [8:0] wrAddr,
  input wire [15:0] wrData,
  input wire [1:0] wrLanes,
  input wire [8:0] rdAddr,
  output reg [15:0] rdData
);
  reg [15:0] mem [0:`REG_WORDS-1];

  // byte lanes written separately so 8-bit hosts touch only one half
  always @(posedge sysClk) begin
    if (wrEn && wrLanes[0]) begin
      mem[wrAddr][7:0] <= wrData[7:0];
    end
    if (wrEn && wrLanes[1]) begin
      mem[wrAddr][15:8] <= wrData[15:8];
    end
    rdData <= mem[rdAddr];
  end
endmodule // host_reg_mem

//--- hdl/host_bus_port.v
// parallel host bus port: strap decode, strobes, wait, busy, irq, data drive
// Function
// - two straps pick strobe, wait, ready 16-bit style or 8-bit style
// - pin roles follow style; strobe style uses rw and lower strobe
// - read and write strobes count only while chip select is low
// - sixteen data bits; byte style uses low byte, upper pulled up
// - interrupt output low when any enabled axis cause is active
// - busy output low while a host access is processed
// - active-low hardware reset returns the port to initial state
// - one reference clock drives all timing
`timescale 1ns/1ns
`include "host_port_defines.vh"
module host_bus_port (
  input wire sysClk,
  input wire rst_n,
  input wire bus_style_strap_low,
  input wire bus_style_strap_high,
  input wire chipSel_n,
  input wire read_n,
  input wire write_n,
  input wire [9:0] addr,
  input wire [15:0] dataIn,
  output reg [15:0] dataOut,
  output reg dataOe,
  output reg wait_request_out,
  output reg interface_busy_out,
  output reg irq_n,
  input wire [3:0] axisIrqCause,
  input wire [3:0] axisIrqEnable,
  output reg [1:0] busStyle
);
  // reset, sequencer and strap state
  reg rstMeta_q;
  reg rstSync_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg isRead_q;
  reg isRead_d;
  reg [1:0] style_q;
  reg styleValid_q;
  // decode and store side nets
  wire rstLocal_n;
  wire selRead;
  wire selWrite;
  wire lowStrobe;
  wire [8:0] wordAddr;
  wire [1:0] lanes;
  wire [15:0] memRd;
  wire memWr;
  wire [15:0] wrWord;
  wire doneNow;
  // load value cut to the counter width on purpose
  localparam [31:0] ACC_LOAD = `ACC_CYC - 1;

  // reset release through two flops, assertion stays asynchronous
  // a release close to the edge must not reach the sequencer unsynchronised
  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstLocal_n = rstSync_q;

  // straps are static; caught once after reset release, not at reset
  // a strap moved later has no effect until the next reset
  always @(posedge sysClk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      style_q <= `STYLE_STROBE;
      styleValid_q <= 1'b0;
    end else if (!styleValid_q) begin
      style_q <= {bus_style_strap_high, bus_style_strap_low};
      styleValid_q <= 1'b1;
    end
  end

  // chip select gates both strobes, so a strobe seen without it is dropped
  // strobe style: write pin is read/not-write, address bit 0 is the data strobe
  assign lowStrobe = (style_q == `STYLE_STROBE) ? ~addr[0] : 1'b1;
  assign selRead = styleValid_q && !chipSel_n &&
    ((style_q == `STYLE_STROBE) ? (write_n && lowStrobe) : !read_n);
  assign selWrite = styleValid_q && !chipSel_n &&
    ((style_q == `STYLE_STROBE) ? (!write_n && lowStrobe) : !write_n);
  // byte style addresses bytes, so bit 0 picks the lane; others use words
  // word styles write both lanes, as there is no upper strobe pin
  assign wordAddr = addr[9:1];
  assign lanes = (style_q == `STYLE_BYTE) ? (addr[0] ? 2'h2 : 2'h1) : 2'h3;
  assign wrWord = (style_q == `STYLE_BYTE) ? {dataIn[7:0], dataIn[7:0]} : dataIn;
  assign memWr = (state_q == `ACC_IDLE) && selWrite;
  assign doneNow = (state_q == `ACC_WORK) && (cnt_q == 8'h00);

  // one store word per word address; read data lag the address by one edge
  // writes land at the take edge, so no held copy of the write data is kept
  host_reg_mem regMem (
    .sysClk(sysClk),
    .wrEn(memWr),
    .wrAddr(wordAddr),
    .wrData(wrWord),
    .wrLanes(lanes),
    .rdAddr(wordAddr),
    .rdData(memRd)
  );

  // access sequencer: idle, fixed processing time, wait for strobe release
  // a new access needs the strobe released first, so one strobe is one access
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    isRead_d = isRead_q;
    case (state_q)
      `ACC_IDLE: begin
        // take a selected strobe and start the processing count
        if (selRead || selWrite) begin
          state_d = `ACC_WORK;
          cnt_d = ACC_LOAD[7:0];
          isRead_d = selRead;
        end
      end
      `ACC_WORK: begin
        // count down the fixed processing time
        if (cnt_q == 8'h00) begin
          state_d = `ACC_DONE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      `ACC_DONE: begin
        // answer stands until the host lets go of the strobe
        if (!selRead && !selWrite) begin
          state_d = `ACC_IDLE;
        end
      end
      default: begin
        state_d = `ACC_IDLE;
      end
    endcase
  end

  // sequencer state registers
  always @(posedge sysClk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      state_q <= `ACC_IDLE;
      cnt_q <= 8'h00;
      isRead_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      isRead_q <= isRead_d;
    end
  end

  // latched strap copy shows the host which style is in force
  always @(posedge sysClk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      busStyle <= `STYLE_STROBE;
    end else begin
      busStyle <= style_q;
    end
  end

  // interrupt: or of all enabled axis causes, one cycle of latency
  always @(posedge sysClk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(axisIrqCause & axisIrqEnable);
    end
  end

  // busy low from the take edge until the count runs out; a short
  // processing time keeps the host wait states few
  always @(posedge sysClk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      interface_busy_out <= 1'b1;
    end else begin
      interface_busy_out <= ~(state_d == `ACC_WORK);
    end
  end

  // strobe style: low acknowledges once the answer stands
  // other styles: low asks the host to wait while processing runs
  always @(posedge sysClk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      wait_request_out <= 1'b1;
    end else if (style_q == `STYLE_STROBE) begin
      wait_request_out <= ~(state_d == `ACC_DONE);
    end else begin
      wait_request_out <= ~(state_d == `ACC_WORK);
    end
  end

  // drive only while selected read is active; released the edge it ends
  always @(posedge sysClk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      dataOe <= 1'b0;
    end else begin
      dataOe <= selRead && (state_d != `ACC_IDLE);
    end
  end

  // read data taken when processing ends and held until the next read
  // byte style shows the pulled-up level on the idle upper lane
  always @(posedge sysClk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      dataOut <= 16'h0000;
    end else if (doneNow && isRead_q) begin
      if (style_q == `STYLE_BYTE) begin
        dataOut <= {`BYTE_PAD, addr[0] ? memRd[15:8] : memRd[7:0]};
      end else begin
        dataOut <= memRd;
      end
    end
  end
endmodule // host_bus_port

//--- bench/host_bus_port_props.sv
// assertions on the host bus port pins
`timescale 1ns/1ns
`include "host_port_defines.vh"
module host_bus_port_props (
  input wire sysClk,
  input wire rst_n,
  input wire chipSel_n,
  input wire dataOe,
  input wire wait_request_out,
  input wire interface_busy_out,
  input wire irq_n,
  input wire [3:0] axisIrqCause,
  input wire [3:0] axisIrqEnable,
  input wire [1:0] busStyle
);
  default clocking @(posedge sysClk); endclocking
  default disable iff (!rst_n);
  wire hit = |(axisIrqCause & axisIrqEnable);
  wire busy = interface_busy_out;
  AST_IRQ_ON: assert property (hit [*3] |=> !irq_n) else $error("irq late");
  AST_IRQ_OFF: assert property (!hit [*3] |=> irq_n) else $error("irq stuck");
  AST_IDLE_CS: assert property (chipSel_n [*2] |=> busy && !dataOe) else $error("unselected");
  AST_OE_SEL: assert property (dataOe |-> $past(!chipSel_n)) else $error("bus driven");
  AST_BUSY_LEN: assert property ($fell(busy) |-> ##3 $rose(busy)) else $error("busy span");
  AST_BUSY_CS: assert property ($fell(busy) |-> $past(!chipSel_n)) else $error("busy cause");
  AST_WAIT: assert property (busStyle != `STYLE_STROBE && $fell(busy) |-> !wait_request_out)
    else $error("no wait");
  AST_ACK: assert property (busStyle == `STYLE_STROBE && $rose(busy) |-> !wait_request_out)
    else $error("no ack");
endmodule // host_bus_port_props
bind host_bus_port host_bus_port_props props (.*);

//--- bench/host_cpu.sv
// host cpu model issuing bus cycles
`timescale 1ns/1ns
`include "host_port_defines.vh"
module host_cpu (
  input wire sysClk,
  input wire [1:0] busStyle,
  input wire interface_busy_out,
  output logic chipSel_n = 1'h1,
  output logic read_n = 1'h1,
  output logic write_n = 1'h1,
  output logic [9:0] addr = 10'h0,
  output logic [15:0] dataIn = 16'h0
);
  // request held until busy returns high; cs low gives an unselected strobe
  task automatic acc(input logic cs, wr, input logic [9:0] a, input logic [15:0] d,
      output int n);
    logic g;
    logic b;
    logic pass0;
    b = busStyle == `STYLE_BYTE;
    pass0 = b | (busStyle == `STYLE_STROBE);
    g = 1'h0;
    n = 0;
    @(posedge sysClk);
    chipSel_n <= !cs;
    read_n <= wr | (busStyle == `STYLE_STROBE);
    write_n <= !wr;
    addr <= {a[9:8], {5{!busStyle[1]}}, a[2:1], pass0 & a[0]};
    dataIn <= {b ? 8'hff : d[15:8], d[7:0]};
    do begin
      @(posedge sysClk);
      n++;
      g |= !interface_busy_out;
    end while (!(g && interface_busy_out) && n < 20);
    {chipSel_n, read_n, write_n} <= 3'h7;
    dataIn <= ~dataIn; // released bus never shows the stale value
  endtask
endmodule // host_cpu

//--- bench/tb.sv
// self-checking bench for the host bus port
`timescale 1ns/1ns
`include "host_port_defines.vh"
module tb;
  logic sysClk = 1'h0, rst_n = 1'h0;
  logic bus_style_strap_low = 1'h0, bus_style_strap_high = 1'h0;
  logic [3:0] axisIrqCause = 4'h0, axisIrqEnable = 4'h0;
  wire chipSel_n, read_n, write_n, dataOe, wait_request_out, interface_busy_out, irq_n;
  wire [9:0] addr;
  wire [15:0] dataIn, dataOut;
  wire [1:0] busStyle;
  int failures = 0, tests_run = 0, n;
  host_bus_port dut (.*);
  host_cpu host (.*);
  initial forever #10 sysClk = ~sysClk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one style from reset: write, read back, unselected strobe, irq
  task automatic run(input logic [1:0] s);
    {bus_style_strap_high, bus_style_strap_low} <= s;
    rst_n <= 1'h0;
    repeat (6) @(posedge sysClk);
    rst_n <= 1'h1;
    repeat (5) @(posedge sysClk);
    chk({dataOe, interface_busy_out, irq_n, busStyle}, {3'h3, s});
    host.acc(1'h1, 1'h1, 10'h102, 16'ha5c3, n);
    chk(n, `ACC_CYC + 2);
    host.acc(1'h1, 1'h0, 10'h102, 16'h0, n);
    chk(n, `ACC_CYC + 2);
    chk({wait_request_out, dataOe}, {s != 2'h0, 1'h1});
    chk(dataOut & (s ? 16'hffff : 16'h00ff), s == 3 ? 16'hffc3 : s ? 16'ha5c3 : 16'hc3);
    // odd address: strobe style has the lower strobe idle, byte style the high lane
    host.acc(1'h1, 1'h1, 10'h103, 16'h5a5a, n);
    chk(n, s ? `ACC_CYC + 2 : 20);
    host.acc(1'h1, 1'h0, 10'h103, 16'h0, n);
    chk(n, s ? `ACC_CYC + 2 : 20);
    chk(dataOut, s == 3 ? 16'hff5a : s ? 16'h5a5a : 16'ha5c3);
    host.acc(1'h0, 1'h0, 10'h102, 16'h0, n);
    chk({interface_busy_out, dataOe, n[4:0]}, {2'h2, 5'h14});
    axisIrqEnable <= 4'h5;
    axisIrqCause <= 4'ha;
    repeat (3) @(posedge sysClk);
    chk(irq_n, 1'h1);
    axisIrqCause <= 4'h4;
    repeat (3) @(posedge sysClk);
    chk(irq_n, 1'h0);
    axisIrqCause <= 4'h0;
  endtask
  initial begin
    for (int s = 0; s < 4; s++) run(s[1:0]);
    summarize;
  end
  // hang guard; the full run needs well under 1000 cycles
  initial begin
    #100000;
    failures++;
    summarize;
  end
endmodule // tb
